// File: rtl/lcgs_pkg.sv
// Package for the logic cell gate input select stage: register map, field layout and carriers.
package lcgs_pkg;
    localparam int LCGS_ADDR_W = 4;
    localparam int LCGS_DATA_W = 8;
    localparam int LCGS_NUM_IN = 4;
    localparam int LCGS_NUM_GATE = 3;
    localparam int LCGS_SRC_W = 6;
    localparam int LCGS_SRC_NUM = 64;
    localparam int LCGS_DEPTH = 16;
    // Register offsets.
    localparam logic [3:0] LCGS_OFF_GATE1_SEL = 4'h0;
    localparam logic [3:0] LCGS_OFF_GATE2_SEL = 4'h1;
    localparam logic [3:0] LCGS_OFF_GATE3_SEL = 4'h2;
    localparam logic [3:0] LCGS_OFF_POLARITY = 4'h3;
    localparam logic [3:0] LCGS_OFF_IN1_SRC = 4'h4;
    localparam logic [3:0] LCGS_OFF_IN2_SRC = 4'h5;
    localparam logic [3:0] LCGS_OFF_IN3_SRC = 4'h6;
    localparam logic [3:0] LCGS_OFF_IN4_SRC = 4'h7;
    localparam logic [3:0] LCGS_OFF_GATE_STATUS = 4'h8;
    // Field positions inside a gate select register: input n true at 2n-1, inverted at 2n-2.
    localparam int LCGS_TRUE_POS = 1;
    localparam int LCGS_INV_POS = 0;
    localparam int LCGS_POL_GATE_MSB = 2;
    localparam logic [7:0] LCGS_READ_ZERO = 8'h00;
    localparam logic [1:0] LCGS_SRC_PAD = 2'h0;
    localparam logic [4:0] LCGS_POL_PAD = 5'h00;
    localparam logic [4:0] LCGS_STAT_PAD = 5'h00;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcgs_bus_req_t;

    typedef struct packed {
        logic gate3;
        logic gate2;
        logic gate1;
    } lcgs_gates_t;
endpackage : lcgs_pkg

// File: rtl/lcgs_reg_mem.sv
// Small register memory with undefined content at reset and registered read data.
`timescale 1ns/10ps
`default_nettype none
module lcgs_reg_mem
    import lcgs_pkg::*;
#(
    parameter int DEPTH = LCGS_DEPTH,
    parameter int WIDTH = LCGS_DATA_W
)
(
    // Clock.
    input wire logic clk_sys_in,
    // Write port.
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read port.
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // No reset: content is unknown at power-up and survives every later reset.
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_en_in)
        begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule // lcgs_reg_mem
`default_nettype wire

// File: rtl/lcgs_gate.sv
// One gate: OR of the selected true and inverted input terms, then optional inversion.
`timescale 1ns/10ps
`default_nettype none
module lcgs_gate
    import lcgs_pkg::*;
#(
    parameter int NUM_IN = LCGS_NUM_IN
)
(
    // Term selection and data.
    input wire logic [2*NUM_IN-1:0] term_en_in,
    input wire logic [NUM_IN-1:0] data_in,
    input wire logic invert_in,
    // Gate result.
    output logic gate_out
);
    logic [2*NUM_IN-1:0] terms;
    logic gate_or;

    genvar i;
    generate
        for (i = 0; i < NUM_IN; i++)
        begin : g_term
            assign terms[2*i+LCGS_TRUE_POS] = data_in[i] & term_en_in[2*i+LCGS_TRUE_POS];
            assign terms[2*i+LCGS_INV_POS] = ~data_in[i] & term_en_in[2*i+LCGS_INV_POS];
        end
    endgenerate

    // An empty selection gives zero at the OR, so gate_out then equals invert_in.
    assign gate_or = |terms;
    assign gate_out = gate_or ^ invert_in;
endmodule // lcgs_gate
`default_nettype wire

// File: rtl/lcgs_top.sv
// Gate input select stage for gates 1 to 3 of a configurable logic cell, with its registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - gate1 bits 7/6 pick input 4 true/inverted
// - gate1 bits 5/4 pick input 3 true/inverted
// - gate1 bits 3/2 pick input 2 true/inverted
// - gate1 bits 1/0 pick input 1 true/inverted
// - gate2 bits 7/6 pick input 4 true/inverted
// - gate2 bits 5/4 pick input 3 true/inverted
// - gate2 bits 3/2 pick input 2 true/inverted
// - gate2 bits 1/0 pick input 1 true/inverted
// - gate3 bits 7/6 pick input 4 true/inverted
// - gate3 bits 5/4 pick input 3 true/inverted
// - gate3 bits 3/2 pick input 2 true/inverted
// - gate3 bits 1/0 pick input 1 true/inverted
// - select registers read/write, undefined, reset-proof
// - polarity bit inverts its gate output
// - each input picked by six-bit source field
module lcgs_top
    import lcgs_pkg::*;
#(
    parameter int NUM_IN = LCGS_NUM_IN,
    parameter int SRC_NUM = LCGS_SRC_NUM
)
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register port.
    input wire logic [LCGS_ADDR_W-1:0] reg_addr_in,
    input wire logic [LCGS_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [LCGS_DATA_W-1:0] reg_rdata_out,
    // Candidate sources for the four data inputs.
    input wire logic [SRC_NUM-1:0] source_in,
    // Gate results towards the cell function.
    output logic gate_one_out,
    output logic gate_two_out,
    output logic gate_three_out
);
    lcgs_bus_req_t req;
    lcgs_gates_t gates_comb;
    lcgs_gates_t gates_q;

    // Shadow copies of the configuration registers; none is reset, so they keep value across resets.
    logic [LCGS_DATA_W-1:0] gate1_term_select_q;
    logic [LCGS_DATA_W-1:0] gate2_term_select_q;
    logic [LCGS_DATA_W-1:0] gate3_term_select_q;
    logic [LCGS_NUM_GATE-1:0] gate_invert_q;
    logic [LCGS_SRC_W-1:0] input1_source_select_q;
    logic [LCGS_SRC_W-1:0] input2_source_select_q;
    logic [LCGS_SRC_W-1:0] input3_source_select_q;
    logic [LCGS_SRC_W-1:0] input4_source_select_q;
    logic rd_pending_q;
    logic rd_is_status_q;
    logic rd_mapped_q;

    logic [LCGS_DATA_W-1:0] mem_rdata;
    logic [NUM_IN-1:0] data_sel;
    logic gate_one_invert;
    logic gate_two_invert;
    logic gate_three_invert;
    logic rd_mapped;
    logic rd_status;
    logic [LCGS_DATA_W-1:0] wr_masked;
    logic [LCGS_DATA_W-1:0] rdata_d;

    assign req.addr = reg_addr_in;
    assign req.wdata = reg_wdata_in;
    assign req.wr = reg_wr_in;
    assign req.rd = reg_rd_in;

    // Unimplemented bits of narrow registers are zeroed on write so reads show zero.
    assign wr_masked = (req.addr == LCGS_OFF_POLARITY) ? {LCGS_POL_PAD, req.wdata[LCGS_POL_GATE_MSB:0]} :
                       (req.addr >= LCGS_OFF_IN1_SRC && req.addr <= LCGS_OFF_IN4_SRC) ?
                       {LCGS_SRC_PAD, req.wdata[LCGS_SRC_W-1:0]} : req.wdata;
    assign rd_mapped = (req.addr <= LCGS_OFF_IN4_SRC);
    assign rd_status = (req.addr == LCGS_OFF_GATE_STATUS);

    // Readback storage; writes to unmapped offsets are stored nowhere visible.
    lcgs_reg_mem #(
        .DEPTH(LCGS_DEPTH),
        .WIDTH(LCGS_DATA_W)
    ) u_mem (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(req.wr & rd_mapped),
        .wr_addr_in(req.addr),
        .wr_data_in(wr_masked),
        .rd_addr_in(req.addr),
        .rd_data_out(mem_rdata)
    );

    // Configuration flops, deliberately without reset.
    always_ff @(posedge clk_sys_in)
    begin
        if (req.wr && req.addr == LCGS_OFF_GATE1_SEL)
        begin
            gate1_term_select_q <= req.wdata;
        end
        if (req.wr && req.addr == LCGS_OFF_GATE2_SEL)
        begin
            gate2_term_select_q <= req.wdata;
        end
        if (req.wr && req.addr == LCGS_OFF_GATE3_SEL)
        begin
            gate3_term_select_q <= req.wdata;
        end
        if (req.wr && req.addr == LCGS_OFF_POLARITY)
        begin
            gate_invert_q <= req.wdata[LCGS_POL_GATE_MSB:0];
        end
        if (req.wr && req.addr == LCGS_OFF_IN1_SRC)
        begin
            input1_source_select_q <= req.wdata[LCGS_SRC_W-1:0];
        end
        if (req.wr && req.addr == LCGS_OFF_IN2_SRC)
        begin
            input2_source_select_q <= req.wdata[LCGS_SRC_W-1:0];
        end
        if (req.wr && req.addr == LCGS_OFF_IN3_SRC)
        begin
            input3_source_select_q <= req.wdata[LCGS_SRC_W-1:0];
        end
        if (req.wr && req.addr == LCGS_OFF_IN4_SRC)
        begin
            input4_source_select_q <= req.wdata[LCGS_SRC_W-1:0];
        end
    end

    // Data input multiplexers.
    assign data_sel[0] = source_in[input1_source_select_q];
    assign data_sel[1] = source_in[input2_source_select_q];
    assign data_sel[2] = source_in[input3_source_select_q];
    assign data_sel[3] = source_in[input4_source_select_q];

    assign gate_one_invert = gate_invert_q[0];
    assign gate_two_invert = gate_invert_q[1];
    assign gate_three_invert = gate_invert_q[2];

    // Bit 2n-1 enables the true term of input n, bit 2n-2 its inverted term.
    lcgs_gate #(.NUM_IN(NUM_IN)) u_gate1 (
        .term_en_in(gate1_term_select_q),
        .data_in(data_sel),
        .invert_in(gate_one_invert),
        .gate_out(gates_comb.gate1)
    );

    lcgs_gate #(.NUM_IN(NUM_IN)) u_gate2 (
        .term_en_in(gate2_term_select_q),
        .data_in(data_sel),
        .invert_in(gate_two_invert),
        .gate_out(gates_comb.gate2)
    );

    lcgs_gate #(.NUM_IN(NUM_IN)) u_gate3 (
        .term_en_in(gate3_term_select_q),
        .data_in(data_sel),
        .invert_in(gate_three_invert),
        .gate_out(gates_comb.gate3)
    );

    // Registered gate outputs: one cycle of latency buys flop-driven outputs.
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gates_q <= '0;
            rd_pending_q <= 1'b0;
            rd_is_status_q <= 1'b0;
            rd_mapped_q <= 1'b0;
        end
        else
        begin
            gates_q <= gates_comb;
            rd_pending_q <= req.rd;
            rd_is_status_q <= rd_status;
            rd_mapped_q <= rd_mapped;
        end
    end

    assign gate_one_out = gates_q.gate1;
    assign gate_two_out = gates_q.gate2;
    assign gate_three_out = gates_q.gate3;

    // Read data: memory word, gate status, or zero for unmapped offsets and idle cycles.
    assign rdata_d = !rd_pending_q ? LCGS_READ_ZERO :
                     rd_is_status_q ? {LCGS_STAT_PAD, gates_q} :
                     rd_mapped_q ? mem_rdata : LCGS_READ_ZERO;
    assign reg_rdata_out = rdata_d;
endmodule // lcgs_top
`default_nettype wire

// File: dv/lcgs_top_assertions.sv
// Port checks for the gate input select stage.
`timescale 1ns/10ps
`default_nettype none
module lcgs_chk
    import lcgs_pkg::*;
#(
    parameter int NUM_IN = LCGS_NUM_IN,
    parameter int SRC_NUM = LCGS_SRC_NUM
)
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register port.
    input wire logic [LCGS_ADDR_W-1:0] reg_addr_in,
    input wire logic [LCGS_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [LCGS_DATA_W-1:0] reg_rdata_out,
    // Sources and gates.
    input wire logic [SRC_NUM-1:0] source_in,
    input wire logic gate_one_out,
    input wire logic gate_two_out,
    input wire logic gate_three_out
);
    // The configuration survives reset, so this shadow is never reset either.
    logic [7:0] cfg_q [0:7];
    logic [7:0] known_q = 8'h00;
    logic [7:0] term;
    logic [2:0] exp_g;
    logic [7:0] rb;
    logic all_k;
    always_ff @(posedge clk_sys_in)
    begin
        if (reg_wr_in && !reg_addr_in[3])
        begin
            cfg_q[reg_addr_in[2:0]] <= reg_wdata_in;
            known_q[reg_addr_in[2:0]] <= 1'b1;
        end
    end
    for (genvar n = 0; n < 4; n++)
    begin : g_t
        assign term[2*n+1] = source_in[cfg_q[4+n][5:0]];
        assign term[2*n] = !term[2*n+1];
    end
    for (genvar k = 0; k < 3; k++)
    begin : g_g
        assign exp_g[k] = (|(cfg_q[k] & term)) ^ cfg_q[3][k];
    end
    assign all_k = &known_q;
    assign rb = cfg_q[reg_addr_in[2:0]] & (reg_addr_in < 4'h3 ? 8'hFF : reg_addr_in == 4'h3 ? 8'h07 : 8'h3F);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    a_gate_one_terms:
        assert property ($past(rst_b_in) && $past(all_k) |-> gate_one_out == $past(exp_g[0]))
        else $error("gate one wrong");
    a_gate_two_terms:
        assert property ($past(rst_b_in) && $past(all_k) |-> gate_two_out == $past(exp_g[1]))
        else $error("gate two wrong");
    a_gate_three_terms:
        assert property ($past(rst_b_in) && $past(all_k) |-> gate_three_out == $past(exp_g[2]))
        else $error("gate three wrong");
    a_empty_gate_low:
        assert property (all_k && cfg_q[1] == 8'h00 && !cfg_q[3][1] ##1 1'b1 |-> !gate_two_out)
        else $error("empty gate not low");
    a_gate_steady:
        assert property (rst_b_in && all_k && !reg_wr_in ##1 $stable(source_in) |=> $stable(gate_one_out))
        else $error("gate moved without cause");
    a_rdata_idle:
        assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside read");
    a_cfg_readback:
        assert property (reg_rd_in && !reg_addr_in[3] && all_k |=> reg_rdata_out == $past(rb))
        else $error("register read back wrong");
    a_hole_zero:
        assert property (reg_rd_in && reg_addr_in > 4'h8 |=> reg_rdata_out == 8'h00)
        else $error("hole read not zero");
    cover property (reg_rd_in && reg_addr_in == 4'h3);
    cover property (reg_wr_in ##1 reg_rd_in);
    cover property ($rose(gate_three_out));
endmodule // lcgs_chk
bind lcgs_top lcgs_chk #(.NUM_IN(NUM_IN), .SRC_NUM(SRC_NUM)) u_chk (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .source_in(source_in), .gate_one_out(gate_one_out),
    .gate_two_out(gate_two_out), .gate_three_out(gate_three_out));
`default_nettype wire

// File: dv/test_lcgs_top.sv
// Self-checking bench for the gate input select stage.
`timescale 1ns/10ps
`default_nettype none
module test_lcgs_top;
    import lcgs_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [63:0] source_in = 64'h0;
    logic [7:0] reg_rdata_out;
    logic g1, g2, g3;
    logic [7:0] shadow [0:7];
    logic [7:0] exp_q [$];
    logic gate_chk = 1'b0;
    logic rd_seen = 1'b0;
    logic gate_seen = 1'b0;
    logic [31:0] seed = 32'h5EA505B4;
    int fail_count = 0;
    int check_count = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    lcgs_top dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .source_in(source_in), .gate_one_out(g1), .gate_two_out(g2), .gate_three_out(g3));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [2:0] gexp();
        logic [7:0] t;
        logic [2:0] g;
        for (int n = 0; n < 4; n++)
        begin
            t[2*n+1] = source_in[shadow[4+n][5:0]];
            t[2*n] = ~t[2*n+1];
        end
        for (int k = 0; k < 3; k++)
            g[k] = (|(shadow[k] & t)) ^ shadow[3][k];
        return g;
    endfunction
    function automatic logic [7:0] rb(input logic [3:0] a);
        if (a < 4'h3) return shadow[a[2:0]];
        if (a == 4'h3) return shadow[3] & 8'h07;
        if (a < 4'h8) return shadow[a[2:0]] & 8'h3F;
        if (a == 4'h8) return {5'h00, gexp()};
        return 8'h00;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobes stay up between calls, so back-to-back requests never assign a strobe twice in one step.
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (r) exp_q.push_back(rb(a));
        if (w && a < 4'h8) shadow[a[2:0]] = d;
        @(posedge clk_sys_in);
    endtask
    task automatic gates();
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        exp_q.push_back({5'h00, gexp()});
        gate_chk <= 1'b1;
        @(posedge clk_sys_in);
        gate_chk <= 1'b0;
    endtask
    always @(posedge clk_sys_in)
    begin
        if (rd_seen) check("read data", reg_rdata_out, exp_q.pop_front());
        if (gate_seen) check("gates", {5'h00, g3, g2, g1}, exp_q.pop_front());
        rd_seen <= reg_rd_in;
        gate_seen <= gate_chk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        logic [31:0] v;
        repeat (10) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int a = 0; a < 8; a++)
        begin
            v = rnd();
            bus(1'b1, 1'b0, a[3:0], (a > 3) ? v[7:0] : 8'h00);
        end
        // Each term alone, with every source seen both ways.
        for (int k = 0; k < 3; k++)
            for (int b = 0; b < 8; b++)
            begin
                bus(1'b1, 1'b0, k[3:0], 8'h01 << b);
                source_in <= {rnd(), rnd()};
                gates();
                source_in <= ~source_in;
                gates();
                bus(1'b1, 1'b0, k[3:0], 8'h00);
            end
        $display("single term test done");
        for (int i = 0; i < 24; i++)
        begin
            for (int a = 0; a < 16; a++)
            begin
                v = rnd();
                bus(1'b1, 1'b0, a[3:0], v[7:0]);
            end
            v = rnd();
            source_in <= {v, rnd()};
            gates();
            for (int a = 0; a < 16; a++)
                bus(1'b0, 1'b1, a[3:0], 8'h00);
        end
        $display("random mix test done");
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int a = 0; a < 8; a++)
            bus(1'b0, 1'b1, a[3:0], 8'h00);
        gates();
        // The last gate note is compared one edge after gates() returns, so wait before the verdict.
        repeat (3) @(posedge clk_sys_in);
        check("notes left", 8'(exp_q.size()), 8'h00);
        $display("warm reset test done");
        tally_and_finish();
    end
endmodule // test_lcgs_top
`default_nettype wire
